// file: logic/segment_lcd_i2c_command_decoder.sv
// I2C target and command decoder of a segment LCD driver, with display memory.
// Assumes SCL and SDA carry external pull-ups; SCL clocks the link logic.
`timescale 1ns/1ps
`include "lcd_defs.svh"

module segment_lcd_i2c_command_decoder
	import lcd_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = `LCD_TGT_ADDR,
	parameter int         DEPTH8      = `LCD_DEPTH8,
	parameter int         DEPTH4      = `LCD_DEPTH4
)(
	input  wire logic                i_clk,
	input  wire logic                i_rst_b,
	input  wire logic                i_scl,
	input  wire logic                i_sda,
	output logic                     o_sda_out,
	output logic                     o_sda_oe,
	output lcd_cfg_t                 o_cfg,
	output logic                     o_display_on,
	output logic                     o_follower_on,
	output logic                     o_low_power,
	output logic [8*DEPTH8-1:0]      o_ram
);
	localparam int IDX = $clog2(DEPTH8);

	logic [1:0]  rst_sync;
	logic        rst_b;
	logic [2:0]  scl_s;
	logic [2:0]  sda_s;
	logic        link_hold_b;
	logic        start_seen;
	logic        stop_seen;

	// Reset release through two flops
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) rst_sync <= 2'h0;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_b = rst_sync[1];

	// Pin synchronisers, third stage for edges
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end else begin
			scl_s <= {scl_s[1:0], i_scl};
			sda_s <= {sda_s[1:0], i_sda};
		end
	end
	assign start_seen = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
	assign stop_seen  = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];

	// Start or stop clears the link logic
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) link_hold_b <= 1'b0;
		else link_hold_b <= !(start_seen || stop_seen);
	end

	// Link side, clocked by SCL
	link_state_t lstate;
	link_state_t next_lstate;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic [7:0]  rx_sh;
	logic [7:0]  rx_byte;
	logic [7:0]  tx_sh;
	logic [7:0]  next_tx_sh;
	logic [7:0]  rd_byte;
	logic        ack_own;
	logic        next_ack_own;
	logic        sda_drive;
	logic        next_sda_drive;
	logic        last_bit;
	logic        ack_slot;
	logic        addr_hit;
	logic        tx_load;
	logic        emit;
	logic        ev_tgl;
	link_event_t ev;
	link_event_t next_ev;

	assign rx_byte      = {rx_sh[6:0], i_sda};
	assign last_bit     = bit_cnt == `LCD_LAST_BIT;
	assign ack_slot     = bit_cnt == `LCD_ACK_SLOT;
	assign addr_hit     = rx_byte[7:1] == TARGET_ADDR;
	assign next_bit_cnt = ack_slot ? `LCD_FIRST_BIT : bit_cnt + 4'h1;
	assign next_ack_own = last_bit && (lstate == L_WRITE || (lstate == L_ADDR && addr_hit));
	assign emit         = last_bit && (lstate != L_DONE) && (lstate != L_ADDR || addr_hit);
	assign next_ev.kind = (lstate == L_ADDR) ? (rx_byte[`LCD_RW_BIT] ? EV_RD_ADDR : EV_WR_ADDR) :
	                      (lstate == L_WRITE) ? EV_DATA : EV_SENT;
	assign next_ev.data = rx_byte;

	always_comb begin
		next_lstate = lstate;
		unique case (lstate)
			L_ADDR: if (last_bit) next_lstate = !addr_hit ? L_DONE : rx_byte[`LCD_RW_BIT] ? L_READ : L_WRITE;
			L_READ: if (ack_slot && i_sda) next_lstate = L_DONE;
			L_WRITE, L_DONE: next_lstate = lstate;
			default: next_lstate = L_DONE;
		endcase
	end

	always_ff @(posedge i_scl or negedge link_hold_b) begin
		if (!link_hold_b) begin
			lstate  <= L_ADDR;
			bit_cnt <= `LCD_FIRST_BIT;
			rx_sh   <= `LCD_FILL_BYTE;
			ack_own <= 1'b0;
		end else begin
			lstate  <= next_lstate;
			bit_cnt <= next_bit_cnt;
			rx_sh   <= rx_byte;
			ack_own <= next_ack_own;
		end
	end

	// Byte event toggle survives start and stop
	always_ff @(posedge i_scl or negedge rst_b) begin
		if (!rst_b) begin
			ev_tgl <= 1'b0;
			ev     <= '0;
		end else if (emit) begin
			ev_tgl <= !ev_tgl;
			ev     <= next_ev;
		end
	end

	// SDA changes only while SCL is low
	assign tx_load        = lstate == L_READ && bit_cnt == `LCD_FIRST_BIT;
	assign next_tx_sh     = tx_load ? {rd_byte[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
	assign next_sda_drive = ack_slot ? ack_own : (lstate == L_READ) && !(tx_load ? rd_byte[7] : tx_sh[7]);

	always_ff @(negedge i_scl or negedge link_hold_b) begin
		if (!link_hold_b) begin
			sda_drive <= 1'b0;
			tx_sh     <= `LCD_FILL_BYTE;
		end else begin
			sda_drive <= next_sda_drive;
			tx_sh     <= next_tx_sh;
		end
	end
	assign o_sda_out = 1'b0;
	assign o_sda_oe  = sda_drive;

	// Command side, clocked by i_clk
	logic [2:0]       ev_sync;
	logic             ev_new;
	dec_state_t       dstate;
	dec_state_t       next_dstate;
	logic [7:0]       cmd;
	logic [5:0]       ptr;
	logic [5:0]       ptr_inc;
	logic [5:0]       depth;
	logic             in_range;
	logic             ev_data_in;
	logic             cmd_known;
	logic             arg_take;
	logic             ram_we;
	logic             ptr_load;
	logic             ptr_step;
	logic [1:0]       mode_r;
	logic [1:0]       sys_r;
	logic             frame_r;
	logic [1:0]       blink_r;
	logic [5:0]       iva_r;
	logic             next_follower;
	logic [7:0]       ram [DEPTH8];

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) ev_sync <= 3'h0;
		else ev_sync <= {ev_sync[1:0], ev_tgl};
	end
	assign ev_new     = ev_sync[2] ^ ev_sync[1];
	assign ev_data_in = ev_new && ev.kind == EV_DATA;
	assign cmd_known  = ev.data inside {`LCD_CMD_DATA, `LCD_CMD_MODE, `LCD_CMD_SYS,
	                                    `LCD_CMD_FRAME, `LCD_CMD_BLINK, `LCD_CMD_IVA};
	assign arg_take   = ev_data_in && dstate == D_ARG;
	assign ptr_load   = arg_take && cmd == `LCD_CMD_DATA;
	assign depth      = mode_r[`LCD_DUTY_BIT] ? 6'(DEPTH8) : 6'(DEPTH4);
	assign in_range   = ptr < depth;
	assign ram_we     = ev_data_in && dstate == D_DATA && in_range;
	assign ptr_step   = (ev_data_in && dstate == D_DATA) || (ev_new && ev.kind == EV_SENT);
	assign ptr_inc    = (ptr >= depth - 6'h1) ? `LCD_PTR_RST : ptr + 6'h1;
	assign rd_byte    = in_range ? ram[ptr[IDX-1:0]] : `LCD_FILL_BYTE;

	always_comb begin
		next_dstate = dstate;
		if (start_seen || stop_seen) next_dstate = D_IDLE;
		else if (ev_new && ev.kind == EV_WR_ADDR) next_dstate = D_CMD;
		else if (ev_new && ev.kind == EV_RD_ADDR) next_dstate = D_IDLE;
		else if (ev_data_in) begin
			unique case (dstate)
				D_CMD: next_dstate = cmd_known ? D_ARG : D_IDLE;
				D_ARG: next_dstate = ptr_load ? D_DATA : D_CMD;
				D_DATA, D_IDLE: next_dstate = dstate;
				default: next_dstate = D_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			dstate <= D_IDLE;
			cmd    <= `LCD_FILL_BYTE;
		end else begin
			dstate <= next_dstate;
			if (ev_data_in && dstate == D_CMD) cmd <= ev.data;
		end
	end

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) ptr <= `LCD_PTR_RST;
		else if (ptr_load) ptr <= ev.data[`LCD_ADDR_F];
		else if (ptr_step) ptr <= ptr_inc;
	end

	// Settings from command arguments
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r  <= `LCD_MODE_RST;
			sys_r   <= `LCD_SYS_RST;
			frame_r <= `LCD_FRAME_RST;
			blink_r <= `LCD_BLINK_RST;
			iva_r   <= `LCD_IVA_RST;
		end else if (arg_take) begin
			if (cmd == `LCD_CMD_MODE) mode_r <= ev.data[`LCD_MODE_F];
			if (cmd == `LCD_CMD_SYS) sys_r <= ev.data[`LCD_SYS_F];
			if (cmd == `LCD_CMD_FRAME) frame_r <= ev.data[`LCD_FRAME_BIT];
			if (cmd == `LCD_CMD_BLINK) blink_r <= ev.data[`LCD_BLINK_F];
			if (cmd == `LCD_CMD_IVA) iva_r <= ev.data[`LCD_IVA_F];
		end
	end
	assign o_cfg = {mode_r, sys_r, frame_r, blink_r, iva_r};

	assign next_follower = iva_r[`LCD_LEVEL_F] != `LCD_LEVEL_OFF &&
	                       !(iva_r[`LCD_SEL_BIT] && !iva_r[`LCD_VE_BIT]);

	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_display_on  <= 1'b0;
			o_follower_on <= 1'b0;
			o_low_power   <= 1'b1;
		end else begin
			o_display_on  <= sys_r[`LCD_OSC_BIT] && sys_r[`LCD_DISP_BIT];
			o_follower_on <= next_follower;
			o_low_power   <= !sys_r[`LCD_OSC_BIT];
		end
	end

	// Display memory, one byte per location
	for (genvar g = 0; g < DEPTH8; g++) begin : g_ram
		always_ff @(posedge i_clk or negedge rst_b) begin
			if (!rst_b) ram[g] <= `LCD_FILL_BYTE;
			else if (ram_we && ptr == 6'(g)) ram[g] <= ev.data;
		end
		assign o_ram[8*g +: 8] = ram[g];
	end

	// Checks
	property p_release_on_stop;
		@(posedge i_clk) disable iff (!rst_b) stop_seen |-> ##2 !o_sda_oe;
	endproperty
	a_release_on_stop: assert property (p_release_on_stop) else $error("SDA held after stop");
	property p_ptr_load;
		@(posedge i_clk) disable iff (!rst_b)
		ev_data_in && dstate == D_ARG && cmd == `LCD_CMD_DATA |=> ptr == $past(ev.data[`LCD_ADDR_F]) && dstate == D_DATA;
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("Start address not loaded");
	property p_ram_write;
		@(posedge i_clk) disable iff (!rst_b) ram_we |=> ram[$past(ptr[IDX-1:0])] == $past(ev.data);
	endproperty
	a_ram_write: assert property (p_ram_write) else $error("Data byte not stored");
	property p_ptr_step;
		@(posedge i_clk) disable iff (!rst_b) ptr_step && !ptr_load |=> ptr == $past(ptr_inc) && ptr != $past(ptr);
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("Pointer did not advance");
	property p_mode_set;
		@(posedge i_clk) disable iff (!rst_b)
		arg_take && cmd == `LCD_CMD_MODE |=> {o_cfg.duty_eighth, o_cfg.bias_quarter} == $past(ev.data[`LCD_MODE_F]);
	endproperty
	a_mode_set: assert property (p_mode_set) else $error("Duty or bias not set");
	property p_osc_gate;
		@(posedge i_clk) disable iff (!rst_b) !o_cfg.osc_enable |=> !o_display_on ##1 (!o_display_on || o_cfg.osc_enable);
	endproperty
	a_osc_gate: assert property (p_osc_gate) else $error("Display on without oscillator");
	property p_blink_set;
		@(posedge i_clk) disable iff (!rst_b)
		arg_take && cmd == `LCD_CMD_BLINK |=> {o_cfg.blink_rate_hi, o_cfg.blink_rate_lo} == $past(ev.data[`LCD_BLINK_F]);
	endproperty
	a_blink_set: assert property (p_blink_set) else $error("Blink rate not set");
	property p_follower_gate;
		@(posedge i_clk) disable iff (!rst_b)
		o_cfg.shared_pin_select && !o_cfg.voltage_adjust_enable ##1 $stable(iva_r) |-> !o_follower_on;
	endproperty
	a_follower_gate: assert property (p_follower_gate) else $error("Follower on for segment pin");
	property p_follower_level;
		@(posedge i_clk) disable iff (!rst_b)
		o_cfg.voltage_level_code == `LCD_LEVEL_OFF |=> !o_follower_on;
	endproperty
	a_follower_level: assert property (p_follower_level) else $error("Follower on at level zero");
	property p_low_power;
		@(posedge i_clk) disable iff (!rst_b)
		(!o_cfg.osc_enable) [*2] |-> o_low_power && !o_display_on;
	endproperty
	a_low_power: assert property (p_low_power) else $error("Low power not entered");
	property p_unknown_cmd;
		@(posedge i_clk) disable iff (!rst_b)
		ev_data_in && dstate == D_CMD && !cmd_known && !start_seen && !stop_seen |=> dstate == D_IDLE ##1 $stable(o_cfg);
	endproperty
	a_unknown_cmd: assert property (p_unknown_cmd) else $error("Unknown command not ignored");
endmodule : segment_lcd_i2c_command_decoder

// file: pkg/lcd_defs.svh
// Commands, reset values, field positions and bit slots of the LCD command decoder.
// Included by the decoder; holds definitions only.
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH
`define LCD_CMD_DATA   8'h80
`define LCD_CMD_MODE   8'h82
`define LCD_CMD_SYS    8'h84
`define LCD_CMD_FRAME  8'h86
`define LCD_CMD_BLINK  8'h88
`define LCD_CMD_IVA    8'h8A
`define LCD_MODE_RST   2'h0
`define LCD_SYS_RST    2'h0
`define LCD_FRAME_RST  1'h0
`define LCD_BLINK_RST  2'h0
`define LCD_IVA_RST    6'h30
`define LCD_PTR_RST    6'h00
`define LCD_FILL_BYTE  8'h00
`define LCD_MODE_F     1:0
`define LCD_SYS_F      1:0
`define LCD_BLINK_F    1:0
`define LCD_IVA_F      5:0
`define LCD_ADDR_F     5:0
`define LCD_LEVEL_F    3:0
`define LCD_FRAME_BIT  0
`define LCD_DUTY_BIT   1
`define LCD_OSC_BIT    1
`define LCD_DISP_BIT   0
`define LCD_SEL_BIT    5
`define LCD_VE_BIT     4
`define LCD_RW_BIT     0
`define LCD_LEVEL_OFF  4'h0
`define LCD_FIRST_BIT  4'h0
`define LCD_LAST_BIT   4'h7
`define LCD_ACK_SLOT   4'h8
`define LCD_TGT_ADDR   7'h3C
`define LCD_DEPTH8     16
`define LCD_DEPTH4     10
`endif

// file: pkg/lcd_pkg.sv
// Types shared by the LCD command decoder.
// No dependencies.
package lcd_pkg;
	typedef enum logic [3:0] {L_ADDR = 4'h1, L_WRITE = 4'h2, L_READ = 4'h4, L_DONE = 4'h8} link_state_t;
	typedef enum logic [3:0] {D_IDLE = 4'h1, D_CMD = 4'h2, D_ARG = 4'h4, D_DATA = 4'h8} dec_state_t;
	typedef enum logic [1:0] {EV_WR_ADDR = 2'h0, EV_RD_ADDR = 2'h1, EV_DATA = 2'h2, EV_SENT = 2'h3} ev_kind_t;
	typedef struct packed {
		ev_kind_t   kind;
		logic [7:0] data;
	} link_event_t;
	typedef struct packed {
		logic       duty_eighth;
		logic       bias_quarter;
		logic       osc_enable;
		logic       display_enable;
		logic       frame_fast;
		logic       blink_rate_hi;
		logic       blink_rate_lo;
		logic       shared_pin_select;
		logic       voltage_adjust_enable;
		logic [3:0] voltage_level_code;
	} lcd_cfg_t;
endpackage : lcd_pkg

// file: test/i2c_host_model.sv
// Behavioural I2C bus controller that drives the decoder's serial pins.
// Assumes a free-running link base clock and an SDA wire resolved with a pull-up.
`timescale 1ns/1ps
module i2c_host_model #(
	parameter int QTR = 25
)(
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe
);
	initial begin
		o_scl    = 1'b1;
		o_sda_oe = 1'b0;
	end

	task automatic q();
		repeat (QTR) @(posedge i_clk);
	endtask : q

	// Start or repeated start; SCL held high a while before the first fall
	task automatic start();
		o_sda_oe <= 1'b0;
		q();
		o_scl <= 1'b1;
		q();
		o_sda_oe <= 1'b1;
		repeat (3) q();
		o_scl <= 1'b0;
		q();
	endtask : start

	// SDA changes only while SCL is low, and is only ever pulled low
	task automatic bit_io(input logic b, output logic s);
		o_sda_oe <= ~b;
		q();
		o_scl <= 1'b1;
		q();
		s = i_sda;
		q();
		o_scl <= 1'b0;
		q();
	endtask : bit_io

	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wr

	task automatic rd(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, s);
	endtask : rd

	// Stop leaves both pins released high
	task automatic stop();
		o_sda_oe <= 1'b1;
		q();
		o_scl <= 1'b1;
		q();
		o_sda_oe <= 1'b0;
		q();
		q();
	endtask : stop
endmodule : i2c_host_model

// file: test/test_segment_lcd_i2c_command_decoder.sv
// Self-checking bench of the LCD command decoder, driven through an I2C host model.
// Assumes the decoder's default target address and memory depths.
`timescale 1ns/1ps
`include "lcd_defs.svh"
module test_segment_lcd_i2c_command_decoder;
	import lcd_pkg::*;
	localparam int LIMIT = 95000;
	logic                i_clk = 1'b0;
	logic                link_clk = 1'b0;
	logic                i_rst_b = 1'b0;
	logic                scl;
	logic                host_oe;
	wire logic           sda;
	logic                o_sda_out;
	logic                o_sda_oe;
	lcd_cfg_t            o_cfg;
	logic                o_display_on;
	logic                o_follower_on;
	logic                o_low_power;
	logic [127:0]        o_ram;
	lcd_cfg_t            exp;
	logic                dead;
	logic                ack;
	logic [7:0]          d;
	int                  n_fail = 0;
	int                  num_checks = 0;
	int                  cyc = 0;
	logic [31:0]         rows [9] = '{32'h8203_8402, 32'h8C00_8200, 32'h86FF_8801, 32'h8A1F_8802,
		32'h8403_8A20, 32'h8A2F_8803, 32'h8A05_8401, 32'h8600_8A00, 32'h8400_8800};

	always #5 i_clk = ~i_clk;
	initial begin
		#3.3;
		forever #6 link_clk = ~link_clk;
	end
	assign sda = !(host_oe | o_sda_oe);

	i2c_host_model host (.i_clk(link_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
	segment_lcd_i2c_command_decoder dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda),
		.o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_cfg(o_cfg), .o_display_on(o_display_on),
		.o_follower_on(o_follower_on), .o_low_power(o_low_power), .o_ram(o_ram));

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic check(input logic [127:0] seen, input logic [127:0] want, input string what);
		num_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch at %0t: %s seen %0h want %0h", $time, what, seen, want);
		end
	endtask : check

	// Expected settings from one command and argument pair
	task automatic apply(input logic [7:0] c, input logic [7:0] a);
		if (!dead) begin
			case (c)
				`LCD_CMD_MODE:  {exp.duty_eighth, exp.bias_quarter} = a[1:0];
				`LCD_CMD_SYS:   {exp.osc_enable, exp.display_enable} = a[1:0];
				`LCD_CMD_FRAME: exp.frame_fast = a[0];
				`LCD_CMD_BLINK: {exp.blink_rate_hi, exp.blink_rate_lo} = a[1:0];
				`LCD_CMD_IVA:   {exp.shared_pin_select, exp.voltage_adjust_enable, exp.voltage_level_code} = a[5:0];
				default:        dead = 1'b1;
			endcase
		end
	endtask : apply

	task automatic chk_cfg();
		check(o_cfg, exp, "settings");
		check(o_display_on, exp.osc_enable & exp.display_enable, "display");
		check(o_follower_on, (exp.voltage_level_code != 4'h0) &
			!(exp.shared_pin_select & !exp.voltage_adjust_enable), "follower");
		check(o_low_power, !exp.osc_enable, "low power");
	endtask : chk_cfg

	// Whole write frame of n bytes, taken MSB first from b
	task automatic send(input logic [63:0] b, input int n);
		host.start();
		host.wr({`LCD_TGT_ADDR, 1'b0}, ack);
		check(ack, 1'b1, "address ack");
		for (int i = 0; i < n; i++) begin
			host.wr(b[63-8*i -: 8], ack);
			check(ack, 1'b1, "byte ack");
		end
		host.stop();
		repeat (8) @(posedge i_clk);
		check({scl, sda, o_sda_out}, 3'b110, "idle pins");
	endtask : send

	task automatic t_reset_and_foreign();
		exp = lcd_cfg_t'({7'h00, `LCD_IVA_RST});
		dead = 1'b0;
		chk_cfg();
		check(o_ram, 128'h0, "memory reset");
		host.start();
		host.wr({`LCD_TGT_ADDR ^ 7'h01, 1'b0}, ack);
		check(ack, 1'b0, "foreign address");
		host.wr(8'h82, ack);
		check(ack, 1'b0, "foreign byte");
		host.wr(8'h03, ack);
		host.stop();
		repeat (8) @(posedge i_clk);
		chk_cfg();
	endtask : t_reset_and_foreign

	// Row 6 is the series-resistor setting with a nonzero level
	task automatic t_settings();
		for (int r = 0; r < 9; r++) begin
			apply(rows[r][31:24], rows[r][23:16]);
			apply(rows[r][15:8], rows[r][7:0]);
			dead = 1'b0;
			send({rows[r], 32'h0}, 4);
			chk_cfg();
		end
	endtask : t_settings

	task automatic t_memory();
		send({64'h8202_800E_D0D1_D200}, 7);
		check(o_ram[8*14 +: 8], 8'hD0, "ram 14");
		check(o_ram[8*15 +: 8], 8'hD1, "ram 15");
		check(o_ram[8*0 +: 8], 8'hD2, "ram 0 wrap");
		send({24'h80C95A, 40'h0}, 3);
		check(o_ram[8*9 +: 8], 8'h5A, "ram 9");
		host.start();
		host.wr({`LCD_TGT_ADDR, 1'b0}, ack);
		host.wr(`LCD_CMD_DATA, ack);
		host.wr(8'h0F, ack);
		host.start();
		host.wr({`LCD_TGT_ADDR, 1'b1}, ack);
		check(ack, 1'b1, "read address ack");
		host.rd(1'b0, d);
		check(d, 8'hD1, "read 15");
		host.rd(1'b0, d);
		check(d, 8'hD2, "read 0");
		host.rd(1'b1, d);
		check(d, 8'h00, "read 1");
		host.stop();
		send({48'h8200_8009_A1A2, 16'h0}, 6);
		check(o_ram[8*9 +: 8], 8'hA1, "quarter ram 9");
		check(o_ram[8*0 +: 8], 8'hA2, "quarter wrap");
		check(o_ram[8*10 +: 8], 8'h00, "ram 10 untouched");
	endtask : t_memory

	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (10) @(posedge i_clk);
		t_reset_and_foreign();
		t_settings();
		t_memory();
		wrap_up();
	end
endmodule : test_segment_lcd_i2c_command_decoder
